// ===== rtl/decode_consts.svh
`ifndef DECODE_CONSTS_SVH
`define DECODE_CONSTS_SVH

// Instruction word width and field positions
`define IW_W          14
`define CAT_FLD       13:12
`define OP_FLD        13:8
`define BOP_FLD       11:10
`define D_BIT         7
`define F_FLD         6:0
`define F_HI_FLD      6:1
`define F_LO_BIT      0
`define B_FLD         9:7
`define K_LONG        10:0
`define K_BYTE        7:0
`define K_RBR         8:0
`define K_IDX         5:0
`define N_BIT         2
`define KN_BIT        6
`define MM_FLD        1:0
`define MOVWI_BIT     3
`define KN_DIR_BIT    7
`define GOTO_BIT      11
`define IND_HI_FLD    13:4
`define RBR_FLD       13:9
`define KN_FLD        13:8

// Category codes in the top two bits
`define CAT_BYTE_CODE 2'h0
`define CAT_BIT_CODE  2'h1
`define CAT_JMP_CODE  2'h2

// Opcode values
`define OP_CTRL       6'h00
`define OP_DECSZ      6'h0b
`define OP_INCSZ      6'h0f
`define OP_RETLIT     6'h34
`define OP_KN         6'h3f
`define BOP_SKC       2'h2
`define BOP_SKS       2'h3
`define RBR_CODE      5'h19
`define IND_HI_CODE   10'h001
`define F_HI_PORT     6'h00
`define W_RETURN      14'h0008
`define W_RETINT      14'h0009
`define W_CALL_VIA_W  14'h000a
`define W_BRANCH_W    14'h000b
`define W_NOP         14'h0000

// Phase timing inside one instruction cycle
`define Q_FIRST       2'h0
`define Q_LAST        2'h3
`define Q_RD_SET      2'h1
`define Q_WR_SET      2'h2

// Zero extension pads for the literal field
`define PAD_BYTE      3'h0
`define PAD_RBR       2'h0
`define PAD_IDX       5'h00

`endif

// ===== rtl/decode_pkg.sv
package decode_pkg;

  // Three opcode categories
  typedef enum logic [1:0] {
    CAT_BYTE = 2'b00,
    CAT_BIT  = 2'b01,
    CAT_LIT  = 2'b10
  } cat_e;

  // Program flow class of an instruction
  typedef enum logic [2:0] {
    FL_NONE = 3'b000,
    FL_CALL = 3'b001,
    FL_RET  = 3'b010,
    FL_JUMP = 3'b011,
    FL_SKIP = 3'b100
  } flow_e;

  // Sequencer states, one per instruction cycle
  typedef enum logic [1:0] {
    ST_EXEC    = 2'b00,
    ST_STRETCH = 2'b01,
    ST_FLUSH   = 2'b10
  } st_e;

  // Decoded instruction
  typedef struct packed {
    cat_e        cat;
    flow_e       flow;
    logic        uses_file;
    logic        indirect;
    logic        dest_f;
    logic        dest_w;
    logic [6:0]  file_addr;
    logic [2:0]  bit_pos;
    logic [10:0] literal;
    logic        ptr_num;
    logic [1:0]  ptr_mode;
  } dec_s;

endpackage

// ===== rtl/instruction_decode_timing.sv
// Overview of operation
// - Takes 14-bit words holding opcode and operands
// - Sorts opcodes into byte, bit, literal/control
// - Other instructions finish in one cycle
// - Both call forms take two cycles
// - All return forms take two cycles
// - Jumps and taken skips take two cycles
// - Indirect access to program memory adds one
// - Instruction cycle is four oscillator clocks
// - File instructions read before they write
// - Destination bit picks accumulator or file
// - File address spans 0x00 to 0x7F
// - Bit field selects one of eight bits
// - Literal field gives data or target
// - Pointer number picks pointer 0 or 1
// - Two-bit mode picks pointer pre/post inc/dec
`include "decode_consts.svh"

module instruction_decode_timing (
  input  wire logic              ref_clk_in,
  input  wire logic              nrst_in,
  input  wire logic              ce_in,
  input  wire logic [13:0]       instr_in,
  input  wire logic              skip_cond_in,
  input  wire logic [1:0]        ptr_prog_in,
  output decode_pkg::dec_s       dec_out,
  output logic [1:0]             phase_out,
  output logic                   cycle_start_out,
  output logic                   fetch_out,
  output logic                   idle_out,
  output logic                   file_rd_out,
  output logic                   file_wr_out,
  output logic                   w_wr_out
);

  // Reset release chain; first flop only feeds the second
  logic              rst_n_meta_q;
  logic              rst_n_q;
  // Sequencer state and stretch flag for the loaded word
  decode_pkg::st_e   state_q;
  decode_pkg::st_e   state_d;
  logic              stretch_q;
  logic              stretch_d;
  // Next decoded word and whether the fetched word is taken
  decode_pkg::dec_s  dec_d;
  logic              consume;
  logic              taken;
  logic              work;
  logic              cyc_end;
  // Helper for the read-before-write check
  logic              rd_seen_q;

  // Splits a 14-bit word into its category and operand fields
  function automatic decode_pkg::dec_s decode(input logic [13:0] w);
    decode_pkg::dec_s r;
    r           = '0;
    r.file_addr = w[`F_FLD];
    r.bit_pos   = w[`B_FLD];
    r.literal   = {`PAD_BYTE, w[`K_BYTE]};
    r.ptr_num   = w[`F_LO_BIT];
    r.ptr_mode  = w[`MM_FLD];
    r.indirect  = (w[`F_HI_FLD] == `F_HI_PORT);
    case (w[`CAT_FLD])
      `CAT_BYTE_CODE:
      begin
        if (w[`OP_FLD] == `OP_CTRL && !w[`D_BIT])
        begin
          // Control group lives in byte space but is literal/control
          r.cat      = decode_pkg::CAT_LIT;
          r.indirect = 1'b0;
          if (w == `W_RETURN || w == `W_RETINT)
            r.flow = decode_pkg::FL_RET;
          else if (w == `W_CALL_VIA_W)
            r.flow = decode_pkg::FL_CALL;
          else if (w == `W_BRANCH_W)
            r.flow = decode_pkg::FL_JUMP;
          else if (w[`IND_HI_FLD] == `IND_HI_CODE)
          begin
            // Pointer move with mode field
            r.uses_file = 1'b1;
            r.indirect  = 1'b1;
            r.ptr_num   = w[`N_BIT];
            r.dest_f    = w[`MOVWI_BIT];
            r.dest_w    = !w[`MOVWI_BIT];
          end
        end
        else
        begin
          r.cat       = decode_pkg::CAT_BYTE;
          r.uses_file = 1'b1;
          r.dest_f    = w[`D_BIT];
          r.dest_w    = !w[`D_BIT];
          if (w[`OP_FLD] == `OP_DECSZ || w[`OP_FLD] == `OP_INCSZ)
            r.flow = decode_pkg::FL_SKIP;
        end
      end
      `CAT_BIT_CODE:
      begin
        r.cat       = decode_pkg::CAT_BIT;
        r.uses_file = 1'b1;
        // Bit tests only read; set and clear write back
        if (w[`BOP_FLD] == `BOP_SKC || w[`BOP_FLD] == `BOP_SKS)
          r.flow = decode_pkg::FL_SKIP;
        else
          r.dest_f = 1'b1;
      end
      `CAT_JMP_CODE:
      begin
        r.cat      = decode_pkg::CAT_LIT;
        r.indirect = 1'b0;
        r.literal  = w[`K_LONG];
        r.flow     = w[`GOTO_BIT] ? decode_pkg::FL_JUMP
                                  : decode_pkg::FL_CALL;
      end
      default:
      begin
        r.cat      = decode_pkg::CAT_LIT;
        r.indirect = 1'b0;
        r.dest_w   = 1'b1;
        if (w[`OP_FLD] == `OP_RETLIT)
          r.flow = decode_pkg::FL_RET;
        else if (w[`RBR_FLD] == `RBR_CODE)
        begin
          r.flow    = decode_pkg::FL_JUMP;
          r.dest_w  = 1'b0;
          r.literal = {`PAD_RBR, w[`K_RBR]};
        end
        else if (w[`KN_FLD] == `OP_KN)
        begin
          // Indexed pointer move with zero-extended six-bit offset
          r.uses_file = 1'b1;
          r.indirect  = 1'b1;
          r.ptr_num   = w[`KN_BIT];
          r.dest_f    = w[`KN_DIR_BIT];
          r.dest_w    = !w[`KN_DIR_BIT];
          r.literal   = {`PAD_IDX, w[`K_IDX]};
        end
      end
    endcase
    return r;
  endfunction

  // Reset release through two flops; frozen with the clock enable
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_n_meta_q <= 1'b0;
      rst_n_q      <= 1'b0;
    end
    else if (ce_in)
    begin
      rst_n_meta_q <= 1'b1;
      rst_n_q      <= rst_n_meta_q;
    end
  end

  // End of the fourth phase closes an instruction cycle
  assign cyc_end = (phase_out == `Q_LAST);
  // Cycle in which the loaded word does its file access
  assign work = (state_q == decode_pkg::ST_EXEC && !stretch_q) ||
                (state_q == decode_pkg::ST_STRETCH);
  // Calls, returns and jumps always redirect; skips on condition
  assign taken = (dec_out.flow == decode_pkg::FL_CALL) ||
                 (dec_out.flow == decode_pkg::FL_RET)  ||
                 (dec_out.flow == decode_pkg::FL_JUMP) ||
                 (dec_out.flow == decode_pkg::FL_SKIP && skip_cond_in);

  // Next state at the cycle boundary
  always_comb
  begin
    state_d   = state_q;
    dec_d     = dec_out;
    stretch_d = stretch_q;
    consume   = 1'b0;
    case (state_q)
      decode_pkg::ST_EXEC:
      begin
        if (stretch_q)
        begin
          // Hold the word one more cycle; nothing is fetched
          state_d   = decode_pkg::ST_STRETCH;
          stretch_d = 1'b0;
        end
        else if (taken)
        begin
          // Prefetched word is dropped and an idle cycle follows
          state_d = decode_pkg::ST_FLUSH;
          dec_d   = decode(`W_NOP);
          consume = 1'b1;
        end
        else
        begin
          dec_d   = decode(instr_in);
          consume = 1'b1;
        end
      end
      decode_pkg::ST_STRETCH:
      begin
        consume = 1'b1;
        if (taken)
        begin
          state_d = decode_pkg::ST_FLUSH;
          dec_d   = decode(`W_NOP);
        end
        else
        begin
          state_d = decode_pkg::ST_EXEC;
          dec_d   = decode(instr_in);
        end
      end
      default:
      begin
        state_d = decode_pkg::ST_EXEC;
        dec_d   = decode(instr_in);
        consume = 1'b1;
      end
    endcase
    // A newly loaded indirect word through a program-memory pointer
    if (consume && state_d == decode_pkg::ST_EXEC)
      stretch_d = dec_d.indirect && ptr_prog_in[dec_d.ptr_num];
  end

  // Phase counter: four oscillator clocks per instruction cycle
  always_ff @(posedge ref_clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
      phase_out <= `Q_LAST;
    else if (ce_in)
      phase_out <= phase_out + 2'h1;
  end

  // Sequencer and instruction register, updated once per cycle
  always_ff @(posedge ref_clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q   <= decode_pkg::ST_FLUSH;
      dec_out   <= '0;
      stretch_q <= 1'b0;
      idle_out  <= 1'b1;
    end
    else if (ce_in && cyc_end)
    begin
      state_q   <= state_d;
      dec_out   <= dec_d;
      stretch_q <= stretch_d;
      idle_out  <= (state_d == decode_pkg::ST_FLUSH);
    end
  end

  // Cycle markers toward program memory
  always_ff @(posedge ref_clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      cycle_start_out <= 1'b0;
      fetch_out       <= 1'b0;
    end
    else if (ce_in)
    begin
      cycle_start_out <= cyc_end;
      fetch_out       <= cyc_end && consume;
    end
  end

  // File and accumulator strobes; read always precedes the write
  always_ff @(posedge ref_clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      file_rd_out <= 1'b0;
      file_wr_out <= 1'b0;
      w_wr_out    <= 1'b0;
    end
    else if (ce_in)
    begin
      // Read even for write-only forms, so side effects stay uniform
      file_rd_out <= work && dec_out.uses_file &&
                     phase_out == `Q_RD_SET;
      file_wr_out <= work && dec_out.uses_file && dec_out.dest_f &&
                     phase_out == `Q_WR_SET;
      w_wr_out    <= work && dec_out.dest_w &&
                     phase_out == `Q_WR_SET;
    end
  end

  // Remembers a read within the current cycle
  always_ff @(posedge ref_clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
      rd_seen_q <= 1'b0;
    else if (ce_in)
      rd_seen_q <= file_rd_out || (rd_seen_q && !cyc_end);
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_q);

  // Cycle boundary; the boundary held in reset at release does not count
  sequence s_end;
    ce_in && cyc_end && rst_n_q;
  endsequence
  sequence s_exec_plain;
    state_q == decode_pkg::ST_EXEC && !stretch_q;
  endsequence

  a_phase_wrap: assert property (s_end |=> phase_out == `Q_FIRST)
    else $error("phase did not wrap after four clocks");
  a_phase_step: assert property (
      ce_in && !cyc_end |=> phase_out == $past(phase_out) + 2'h1)
    else $error("phase did not advance");
  a_call_ret_flush: assert property (
      s_exec_plain ##0 s_end ##0
      (dec_out.flow == decode_pkg::FL_CALL ||
       dec_out.flow == decode_pkg::FL_RET) |=>
      state_q == decode_pkg::ST_FLUSH && idle_out)
    else $error("call or return not given a second cycle");
  a_skip_taken: assert property (
      s_exec_plain ##0 s_end ##0
      dec_out.flow == decode_pkg::FL_SKIP && skip_cond_in |=>
      state_q == decode_pkg::ST_FLUSH)
    else $error("taken skip not given a second cycle");
  a_single_cycle: assert property (
      s_exec_plain ##0 s_end ##0 !taken |=>
      state_q == decode_pkg::ST_EXEC && !idle_out)
    else $error("plain instruction took more than one cycle");
  a_stretch_extra: assert property (
      s_end ##0 state_q == decode_pkg::ST_EXEC && stretch_q |=>
      state_q == decode_pkg::ST_STRETCH && !fetch_out)
    else $error("indirect program-memory access not stretched");
  a_flush_idle: assert property (
      s_end ##0 state_d == decode_pkg::ST_FLUSH |=>
      dec_out.flow == decode_pkg::FL_NONE &&
      !dec_out.uses_file && !dec_out.dest_w)
    else $error("fetched word not replaced by an idle cycle");
  a_rmw_order: assert property ($rose(file_wr_out) |-> rd_seen_q)
    else $error("file written without a prior read");
  a_dest_route: assert property (
      w_wr_out |-> !file_wr_out && !dec_out.dest_f)
    else $error("result routed to both destinations");

endmodule

// ===== testbench/prog_mem_model.sv
// Program memory as seen by the decoder: word 0 is the word under test,
// word 1 writes the accumulator so that a wrongly executed discarded word
// shows up as a strobe, and all later words are idle words.
module prog_mem_model (
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        ce_in,
  input  wire logic        fetch_in,
  input  wire logic [13:0] first_in,
  output logic      [13:0] instr_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] addr_q; // Word address, saturates on the idle words

  // Advance once per consumed word; a frozen core must not advance it
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      addr_q <= 2'h0;
    else if (ce_in && fetch_in && addr_q != 2'h3)
      addr_q <= addr_q + 2'h1;
  end

  // Word shown for the current address
  always_comb
  begin
    case (addr_q)
      2'h0:    instr_out = first_in;
      2'h1:    instr_out = 14'h0725;
      default: instr_out = 14'h0000;
    endcase
  end
endmodule

// ===== testbench/tb_instruction_decode_timing.sv
module tb_instruction_decode_timing;
  timeunit 1ns;
  timeprecision 1ps;

  // One case: stimulus, then expected results
  typedef struct packed {
    logic [13:0] word; // Word under test
    logic [1:0]  ptr;  // Pointers aimed at program memory
    logic        skip; // Skip condition
    logic [1:0]  cyc;  // Instruction cycles taken
    logic [1:0]  cat;  // Category; 3 skips category and strobe checks
    logic [2:0]  flow; // Flow class
    logic [2:0]  str;  // File read, file write, accumulator write
    logic        nv;   // Operand field not checked
    logic [1:0]  sel;  // Field: file, literal, bit, pointer
    logic [10:0] val;  // Expected field
  } row_s;

  row_s rows [27] = '{
    {14'h07A5,2'h0,1'b0,2'h1,2'h0,3'h0,3'h6,1'b0,2'h0,11'h025},
    {14'h0725,2'h0,1'b0,2'h1,2'h0,3'h0,3'h5,1'b0,2'h0,11'h025},
    {14'h00FF,2'h0,1'b0,2'h1,2'h0,3'h0,3'h6,1'b0,2'h0,11'h07F},
    {14'h0B90,2'h0,1'b1,2'h2,2'h0,3'h4,3'h6,1'b0,2'h0,11'h010},
    {14'h0B90,2'h0,1'b0,2'h1,2'h0,3'h4,3'h6,1'b0,2'h0,11'h010},
    {14'h0F90,2'h0,1'b1,2'h2,2'h0,3'h4,3'h6,1'b0,2'h0,11'h010},
    {14'h1FA0,2'h0,1'b1,2'h2,2'h1,3'h4,3'h4,1'b0,2'h2,11'h007},
    {14'h1B20,2'h0,1'b1,2'h2,2'h1,3'h4,3'h4,1'b0,2'h2,11'h006},
    {14'h1005,2'h0,1'b0,2'h1,2'h1,3'h0,3'h6,1'b0,2'h2,11'h000},
    {14'h2123,2'h0,1'b0,2'h2,2'h2,3'h1,3'h0,1'b0,2'h1,11'h123},
    {14'h2FFF,2'h0,1'b0,2'h2,2'h2,3'h3,3'h0,1'b0,2'h1,11'h7FF},
    {14'h345A,2'h0,1'b0,2'h2,2'h2,3'h2,3'h1,1'b0,2'h1,11'h05A},
    {14'h33FF,2'h0,1'b0,2'h2,2'h2,3'h3,3'h0,1'b0,2'h1,11'h1FF},
    {14'h3042,2'h0,1'b0,2'h1,2'h2,3'h0,3'h1,1'b0,2'h1,11'h042},
    {14'h0008,2'h0,1'b0,2'h2,2'h3,3'h2,3'h0,1'b1,2'h0,11'h000},
    {14'h0009,2'h0,1'b0,2'h2,2'h3,3'h2,3'h0,1'b1,2'h0,11'h000},
    {14'h000A,2'h0,1'b0,2'h2,2'h3,3'h1,3'h0,1'b1,2'h0,11'h000},
    {14'h000B,2'h0,1'b0,2'h2,2'h3,3'h3,3'h0,1'b1,2'h0,11'h000},
    {14'h0780,2'h1,1'b0,2'h2,2'h0,3'h0,3'h6,1'b0,2'h0,11'h000},
    {14'h0780,2'h2,1'b0,2'h1,2'h0,3'h0,3'h6,1'b0,2'h0,11'h000},
    {14'h0781,2'h2,1'b0,2'h2,2'h0,3'h0,3'h6,1'b0,2'h0,11'h001},
    {14'h0B80,2'h1,1'b1,2'h3,2'h0,3'h4,3'h6,1'b0,2'h0,11'h000},
    {14'h0010,2'h0,1'b0,2'h1,2'h3,3'h0,3'h0,1'b0,2'h3,11'h000},
    {14'h0015,2'h0,1'b0,2'h1,2'h3,3'h0,3'h0,1'b0,2'h3,11'h005},
    {14'h0012,2'h0,1'b0,2'h1,2'h3,3'h0,3'h0,1'b0,2'h3,11'h002},
    {14'h0017,2'h0,1'b0,2'h1,2'h3,3'h0,3'h0,1'b0,2'h3,11'h007},
    {14'h3F45,2'h2,1'b0,2'h2,2'h2,3'h0,3'h5,1'b0,2'h1,11'h005}
  };

  logic             ref_clk_in   = 1'b0;
  logic             nrst_in      = 1'b0;
  logic             ce_in        = 1'b1;
  logic             skip_cond_in = 1'b0;
  logic [1:0]       ptr_prog_in  = 2'h0;
  logic [13:0]      first_w      = 14'h0000; // Word 0 of the memory
  logic [13:0]      instr_in;
  decode_pkg::dec_s dec_out;
  logic [1:0]       phase_out;
  logic             cycle_start_out;
  logic             fetch_out;
  logic             idle_out;
  logic             file_rd_out;
  logic             file_wr_out;
  logic             w_wr_out;
  logic [1:0]       ph;
  int               num_errors   = 0;
  int               n_tests      = 0;
  int               i;

  // Free-running 100 MHz clock
  always #5 ref_clk_in = ~ref_clk_in;

  instruction_decode_timing instruction_decode_timing_i (
    .ref_clk_in      (ref_clk_in),
    .nrst_in         (nrst_in),
    .ce_in           (ce_in),
    .instr_in        (instr_in),
    .skip_cond_in    (skip_cond_in),
    .ptr_prog_in     (ptr_prog_in),
    .dec_out         (dec_out),
    .phase_out       (phase_out),
    .cycle_start_out (cycle_start_out),
    .fetch_out       (fetch_out),
    .idle_out        (idle_out),
    .file_rd_out     (file_rd_out),
    .file_wr_out     (file_wr_out),
    .w_wr_out        (w_wr_out)
  );

  prog_mem_model prog_mem_model_i (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .ce_in      (ce_in),
    .fetch_in   (fetch_out),
    .first_in   (first_w),
    .instr_out  (instr_in)
  );

  // Closing report; also the exit of every exhausted wait
  task automatic end_sim;
    $display("compares %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Four-state compare; wide enough for the whole decoded word
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Inputs move a fixed 1 ns after the edge; outputs have settled then
  task automatic tick;
    @(posedge ref_clk_in);
    #1;
  endtask

  // Reset, check the idle state, release, wait for the first word
  task automatic do_reset;
    nrst_in = 1'b0;
    repeat (12) tick();
    chk(phase_out, 2'h3);
    chk({idle_out, dec_out}, {1'b1, 33'h0});
    chk({cycle_start_out, fetch_out, file_rd_out, file_wr_out, w_wr_out}, 0);
    nrst_in = 1'b1;
    i = 0;
    while (i < 8 && cycle_start_out !== 1'b1)
    begin
      tick();
      i++;
    end
    if (cycle_start_out !== 1'b1)
    begin
      num_errors++;
      end_sim();
    end
  endtask

  // Run one word and measure its length and strobes
  task automatic run_row(input row_s r);
    int          clks;
    int          n_rd;
    int          n_wr;
    int          n_w;
    logic [10:0] fld;
    clks = 0;
    n_rd = 0;
    n_wr = 0;
    n_w = 0;
    first_w = r.word;
    ptr_prog_in = r.ptr;
    skip_cond_in = r.skip;
    do_reset();
    case (r.sel)
      2'h0:    fld = {4'h0, dec_out.file_addr};
      2'h1:    fld = dec_out.literal;
      2'h2:    fld = {8'h00, dec_out.bit_pos};
      default: fld = {8'h00, dec_out.ptr_num, dec_out.ptr_mode};
    endcase
    if (!r.nv && r.sel[1])
      chk(fld, r.val);
    if (!r.nv && !r.sel[1])
      chk(fld, r.val);
    if (r.cat != 2'h3)
      chk(dec_out.cat, r.cat);
    chk(dec_out.flow, r.flow);
    // Bounded walk up to the next word that really starts
    while (clks < 24)
    begin
      tick();
      clks++;
      if (file_rd_out === 1'b1)
      begin
        n_rd++;
        chk(phase_out, 2'h2);
      end
      if (file_wr_out === 1'b1)
      begin
        n_wr++;
        chk(phase_out, 2'h3);
      end
      if (w_wr_out === 1'b1)
        n_w++;
      if (idle_out === 1'b1)
        chk(dec_out.flow, 3'h0);
      if (cycle_start_out === 1'b1 && fetch_out === 1'b1 && idle_out === 1'b0)
        break;
    end
    // A word that never hands over ends the run
    if (clks == 24)
    begin
      num_errors++;
      end_sim();
    end
    if (r.cyc == 2'h1)
      chk(clks, 4);
    else
      chk(clks, 4 * r.cyc);
    // Strobe counts, one compare each so no count is cut off
    if (r.cat != 2'h3)
    begin
      chk(n_rd, r.str[2]);
      chk(n_wr, r.str[1]);
      chk(n_w, r.str[0]);
    end
  endtask

  initial
  begin
    // Table of ordinary cases, each behind its own reset
    foreach (rows[k])
    begin
      run_row(rows[k]);
      $display("case %0d done", k);
    end
    // Clock enable low freezes the cycle; four enabled clocks remain one
    first_w = 14'h07A5;
    ptr_prog_in = 2'h0;
    skip_cond_in = 1'b0;
    do_reset();
    tick();
    ce_in = 1'b0;
    ph = phase_out;
    repeat (5) tick();
    chk(phase_out, ph);
    ce_in = 1'b1;
    i = 0;
    while (i < 9 && cycle_start_out !== 1'b1)
    begin
      tick();
      i++;
    end
    chk(i, 3);
    $display("clock enable case done");
    end_sim();
  end
endmodule
